// file: hw/bas_pkg.sv
// What this block does
// - Register-subtract computes register minus accumulator
// - Destination zero to accumulator, one to register
// - Carry and nibble carry set when no borrow
// - Literal xor into accumulator, zero flag only
// - Register xor to destination, zero flag only
// - Swap register nibbles, no flag changes
package bas_pkg;

  localparam int DATA_W = 8;
  localparam int ADDR_W = 7;
  localparam logic [ADDR_W-1:0] ADDR_MAX = 7'h7f;
  localparam logic [DATA_W-1:0] ACC_RST = 8'h00;
  localparam logic DEST_ACC = 1'b0;
  localparam logic DEST_REG = 1'b1;
  localparam int NIB_LO = 3;
  localparam int NIB_HI = 7;

  typedef enum logic [1:0] {
    BAS_SUB_ACC_FROM_REG,
    BAS_XOR_LITERAL_INTO_ACC,
    BAS_XOR_ACC_WITH_REG,
    BAS_SWAP_REG_NIBBLES
  } bas_op_t;

  typedef struct packed {
    logic valid;
    bas_op_t op;
    logic dest;
    logic [ADDR_W-1:0] reg_addr;
    logic [DATA_W-1:0] reg_data;
    logic [DATA_W-1:0] literal;
  } bas_req_t;

  typedef struct packed {
    logic carry;
    logic nibble_carry_flag;
    logic zero;
  } bas_flags_t;

  typedef struct packed {
    logic wr_en;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } bas_regwr_t;

  typedef struct packed {
    logic [DATA_W-1:0] acc;
    bas_flags_t flags;
    bas_regwr_t regwr;
    logic done;
  } bas_state_t;

endpackage

// file: hw/bas_alu.sv
`timescale 1ns/1ps
`default_nettype none
module bas_alu (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // Operation request
  input wire bas_pkg::bas_req_t req,
  // Results
  output logic [bas_pkg::DATA_W-1:0] acc,
  output bas_pkg::bas_flags_t flags,
  output bas_pkg::bas_regwr_t regwr,
  output logic done
);
  import bas_pkg::*;

  bas_state_t st_r;
  bas_state_t st_nxt;
  logic [DATA_W:0] diff;
  logic [NIB_LO+1:0] ndiff;
  logic [DATA_W-1:0] res;

  function automatic logic is_zero(input logic [DATA_W-1:0] v);
    return v == '0;
  endfunction

  always_comb begin
    st_nxt = st_r;
    st_nxt.done = 1'b0;
    st_nxt.regwr.wr_en = 1'b0;
    diff = {1'b0, req.reg_data} - {1'b0, st_r.acc};
    ndiff = {1'b0, req.reg_data[NIB_LO:0]} - {1'b0, st_r.acc[NIB_LO:0]};
    res = '0;
    if (req.valid) begin
      st_nxt.done = 1'b1;
      unique case (req.op)
        BAS_SUB_ACC_FROM_REG: begin
          res = diff[DATA_W-1:0];
          st_nxt.flags.carry = ~diff[DATA_W];
          st_nxt.flags.nibble_carry_flag = ~ndiff[NIB_LO+1];
          st_nxt.flags.zero = is_zero(res);
        end
        BAS_XOR_LITERAL_INTO_ACC: begin
          res = st_r.acc ^ req.literal;
          st_nxt.flags.zero = is_zero(res);
        end
        BAS_XOR_ACC_WITH_REG: begin
          res = st_r.acc ^ req.reg_data;
          st_nxt.flags.zero = is_zero(res);
        end
        BAS_SWAP_REG_NIBBLES: begin
          res = {req.reg_data[NIB_LO:0], req.reg_data[NIB_HI:NIB_LO+1]};
        end
      endcase
      if (req.op == BAS_XOR_LITERAL_INTO_ACC || req.dest == DEST_ACC) begin
        st_nxt.acc = res;
      end else begin
        st_nxt.regwr.wr_en = 1'b1;
        st_nxt.regwr.addr = req.reg_addr;
        st_nxt.regwr.data = res;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      st_r <= '{acc: ACC_RST, default: '0};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign acc = st_r.acc;
  assign flags = st_r.flags;
  assign regwr = st_r.regwr;
  assign done = st_r.done;

  // Subtract
  a_sub_result: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    req.valid && req.op == BAS_SUB_ACC_FROM_REG && req.dest == DEST_ACC
    |=> acc == 8'($past(req.reg_data) - $past(acc)))
    else $error("subtract result wrong");

  a_sub_reg_data: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    req.valid && req.op == BAS_SUB_ACC_FROM_REG && req.dest == DEST_REG
    |=> regwr.data == 8'($past(req.reg_data) - $past(acc)))
    else $error("subtract register result wrong");

  a_sub_carry: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    req.valid && req.op == BAS_SUB_ACC_FROM_REG
    |=> flags.carry == ($past(acc) <= $past(req.reg_data)))
    else $error("carry wrong");

  a_sub_ncarry: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    req.valid && req.op == BAS_SUB_ACC_FROM_REG
    |=> flags.nibble_carry_flag ==
        ($past(acc[NIB_LO:0]) <= $past(req.reg_data[NIB_LO:0])))
    else $error("nibble carry wrong");

  a_sub_zero: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    req.valid && req.op == BAS_SUB_ACC_FROM_REG
    |=> flags.zero ==
        (8'($past(req.reg_data) - $past(acc)) == 8'h00))
    else $error("subtract zero flag wrong");

  // Destination
  a_dest_reg: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    req.valid && req.op != BAS_XOR_LITERAL_INTO_ACC && req.dest == DEST_REG
    |=> regwr.wr_en && regwr.addr == $past(req.reg_addr) && $stable(acc))
    else $error("register destination not written");

  a_dest_acc: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    req.valid && (req.op == BAS_XOR_LITERAL_INTO_ACC || req.dest == DEST_ACC)
    |=> !regwr.wr_en && $stable(regwr.addr) && $stable(regwr.data))
    else $error("accumulator destination wrote register");

  a_regwr_pulse: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    regwr.wr_en |-> done)
    else $error("register write without an operation");

  // Exclusive OR
  a_xorl_flags: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    req.valid && req.op == BAS_XOR_LITERAL_INTO_ACC
    |=> !regwr.wr_en && acc == ($past(acc) ^ $past(req.literal))
        && flags.carry == $past(flags.carry))
    else $error("literal xor wrong");

  a_xorl_ncarry: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    req.valid && req.op == BAS_XOR_LITERAL_INTO_ACC
    |=> $stable(flags.nibble_carry_flag))
    else $error("literal xor touched nibble carry");

  a_xorf_flags: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    req.valid && req.op == BAS_XOR_ACC_WITH_REG
    |=> $stable(flags.carry) && $stable(flags.nibble_carry_flag))
    else $error("register xor touched carry");

  a_xorf_acc: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    req.valid && req.op == BAS_XOR_ACC_WITH_REG && req.dest == DEST_ACC
    |=> acc == ($past(acc) ^ $past(req.reg_data)))
    else $error("register xor accumulator result wrong");

  a_xorf_reg: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    req.valid && req.op == BAS_XOR_ACC_WITH_REG && req.dest == DEST_REG
    |=> regwr.data == ($past(acc) ^ $past(req.reg_data)))
    else $error("register xor register result wrong");

  // Nibble swap
  a_swap_data: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    req.valid && req.op == BAS_SWAP_REG_NIBBLES && req.dest == DEST_REG
    |=> regwr.data == {$past(req.reg_data[NIB_LO:0]),
        $past(req.reg_data[NIB_HI:NIB_LO+1])} && $stable(flags))
    else $error("swap wrong");

  a_swap_acc: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    req.valid && req.op == BAS_SWAP_REG_NIBBLES && req.dest == DEST_ACC
    |=> acc == {$past(req.reg_data[NIB_LO:0]),
        $past(req.reg_data[NIB_HI:NIB_LO+1])} && $stable(flags))
    else $error("swap to accumulator wrong");

  // Zero flag
  a_zero_flag: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    req.valid && req.op != BAS_SWAP_REG_NIBBLES
    && (req.dest == DEST_ACC || req.op == BAS_XOR_LITERAL_INTO_ACC)
    |=> flags.zero == (acc == 8'h00))
    else $error("zero flag wrong");

  a_zero_reg: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    req.valid && req.dest == DEST_REG && req.op != BAS_SWAP_REG_NIBBLES
    && req.op != BAS_XOR_LITERAL_INTO_ACC
    |=> flags.zero == (regwr.data == 8'h00))
    else $error("zero flag of register result wrong");

  // Idle and done pulse
  a_idle_quiet: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    !req.valid |=> !done && !regwr.wr_en)
    else $error("spurious activity");

  a_idle_hold: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    !req.valid |=> $stable(acc) && $stable(flags)
        && $stable(regwr.addr) && $stable(regwr.data))
    else $error("state changed while idle");

  a_done_pulse: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    req.valid |=> done)
    else $error("done missing after request");

  // Main scenarios
  c_sub_borrow: cover property (@(posedge clk_sys) disable iff (!resetn)
    req.valid && req.op == BAS_SUB_ACC_FROM_REG ##1 !flags.carry);

  c_xor_zero: cover property (@(posedge clk_sys) disable iff (!resetn)
    req.valid && req.op == BAS_XOR_LITERAL_INTO_ACC ##1 flags.zero);

  c_swap_reg: cover property (@(posedge clk_sys) disable iff (!resetn)
    req.valid && req.op == BAS_SWAP_REG_NIBBLES && req.dest == DEST_REG);

  c_xorf_zero: cover property (@(posedge clk_sys) disable iff (!resetn)
    req.valid && req.op == BAS_XOR_ACC_WITH_REG && req.dest == DEST_REG
    ##1 flags.zero);

  c_back_to_back: cover property (@(posedge clk_sys) disable iff (!resetn)
    req.valid ##1 req.valid);
endmodule
`default_nettype wire

// file: tb/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import bas_pkg::*;
  logic clk_sys = 1'b0;
  logic resetn = 1'b0;
  bas_req_t req = '0;
  logic [7:0] acc;
  bas_flags_t flags;
  bas_regwr_t regwr;
  logic done;
  int n_errors = 0;
  int comparisons = 0;
  int cycles = 0;
  always #25 clk_sys = ~clk_sys;
  bas_alu i_dut (.clk_sys(clk_sys), .resetn(resetn), .req(req),
    .acc(acc), .flags(flags), .regwr(regwr), .done(done));
  task automatic final_report;
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 300) begin
      n_errors++;
      final_report();
    end
  end
  task automatic chk(string nm, logic [7:0] e, logic [7:0] g);
    comparisons++;
    if (g !== e) begin
      n_errors++;
      $display("ERROR %s exp %h got %h", nm, e, g);
    end
  endtask
  // One op; the byte is both register value and literal
  task automatic op(bas_op_t o, logic d, logic [6:0] a, logic [7:0] r);
    logic [7:0] exp_wr;
    exp_wr = {7'h00, d && o != BAS_XOR_LITERAL_INTO_ACC};
    @(posedge clk_sys);
    req <= '{1'b1, o, d, a, r, r};
    #1;
    chk("idle done", 8'h00, {7'h00, done});
    chk("idle wr_en", 8'h00, {7'h00, regwr.wr_en});
    @(posedge clk_sys);
    req.valid <= 1'b0;
    #1;
    chk("done", 8'h01, {7'h00, done});
    chk("wr_en", exp_wr, {7'h00, regwr.wr_en});
  endtask
  task automatic res(logic [7:0] a, logic [2:0] f);
    chk("acc", a, acc);
    chk("flags", {5'h00, f}, {5'h00, flags});
  endtask
  task automatic wr(logic [6:0] a, logic [7:0] dt);
    chk("wr_addr", {1'b0, a}, {1'b0, regwr.addr});
    chk("wr_data", dt, regwr.data);
  endtask
  task automatic t_xorl;
    op(BAS_XOR_LITERAL_INTO_ACC, 1'b1, 7'h00, 8'h3c);
    res(8'h3c, 3'b000);
    op(BAS_XOR_LITERAL_INTO_ACC, 1'b0, 7'h00, 8'h3c);
    res(8'h00, 3'b001);
    $display("test xor literal done");
  endtask
  task automatic t_sub;
    op(BAS_XOR_LITERAL_INTO_ACC, 1'b0, 7'h00, 8'h13);
    op(BAS_SUB_ACC_FROM_REG, 1'b0, 7'h7f, 8'h12);
    res(8'hff, 3'b000);
    op(BAS_SUB_ACC_FROM_REG, 1'b1, 7'h7f, 8'hff);
    res(8'hff, 3'b111);
    wr(7'h7f, 8'h00);
    op(BAS_XOR_LITERAL_INTO_ACC, 1'b0, 7'h00, 8'hf0);
    op(BAS_SUB_ACC_FROM_REG, 1'b0, 7'h10, 8'h20);
    res(8'h11, 3'b100);
    $display("test subtract done");
  endtask
  task automatic t_xorw;
    op(BAS_XOR_ACC_WITH_REG, 1'b0, 7'h05, 8'h0f);
    res(8'h1e, 3'b100);
    op(BAS_XOR_ACC_WITH_REG, 1'b1, 7'h05, 8'h1e);
    res(8'h1e, 3'b101);
    wr(7'h05, 8'h00);
    $display("test xor register done");
  endtask
  task automatic t_swap;
    op(BAS_SWAP_REG_NIBBLES, 1'b0, 7'h00, 8'ha5);
    res(8'h5a, 3'b101);
    op(BAS_SWAP_REG_NIBBLES, 1'b1, 7'h01, 8'h3c);
    res(8'h5a, 3'b101);
    wr(7'h01, 8'hc3);
    $display("test swap done");
  endtask
  initial begin
    repeat (5) @(posedge clk_sys);
    resetn <= 1'b1;
    t_xorl();
    t_sub();
    t_xorw();
    t_swap();
    final_report();
  end
endmodule
`default_nettype wire
